// file: oled_cmd_params.svh
`ifndef OLED_CMD_PARAMS_SVH
`define OLED_CMD_PARAMS_SVH

// Opcodes
`define OP_DISP_OFF 8'hae
`define OP_DISP_ON 8'haf
`define OP_MODE_NORMAL 8'ha4
`define OP_CLOCK_DIV 8'hb3
`define OP_OFFSET 8'ha2
`define OP_MUX 8'hc8
`define OP_MASTER_CFG 8'had
`define OP_START_LINE 8'ha1
`define OP_REMAP 8'ha0
`define OP_MASTER_CUR 8'h87
`define OP_CONTRAST_A 8'h81
`define OP_CONTRAST_B 8'h82
`define OP_CONTRAST_C 8'h83
`define OP_PRECHARGE 8'hbb
`define OP_PRE2_A 8'h8a
`define OP_PRE2_B 8'h8b
`define OP_PRE2_C 8'h8c
`define OP_DESELECT 8'hbe
`define OP_PHASE 8'hb1
`define OP_POWER_SAVE 8'hb0
`define OP_COL_WIN 8'h15
`define OP_ROW_WIN 8'h75

// Reset values and the external-drive master configuration parameter
`define RST_MUX 8'h3f
`define RST_ZERO 8'h00
`define RST_MASTER_CUR 4'hf
`define RST_CONTRAST 8'h80
`define RST_MODE 2'h0
`define RST_MASTER_CFG 8'h8f
`define MASTER_CFG_EXT 8'h8e
`define RST_CLOCK_DIV 8'h00
`define RST_PRECHARGE 8'h00
`define RST_DESELECT 5'h00
`define RST_PHASE 8'h00
`define RST_POWER_SAVE 8'h00
`define RST_COL_END 8'h5f
`define RST_ROW_END 8'h3f

`endif

// file: oled_cmd_pkg.sv
package oled_cmd_pkg;

  typedef enum logic [1:0] {
    MODE_NORMAL,
    MODE_ALL_ON,
    MODE_ALL_OFF,
    MODE_INVERSE
  } disp_mode_type;

  typedef struct packed {
    logic display_on;
    disp_mode_type mode;
    logic [7:0] mux_ratio;
    logic [7:0] start_line;
    logic [7:0] offset;
    logic [7:0] remap;
    logic [7:0] clock_div;
    logic [7:0] master_cfg;
    logic [3:0] master_current;
    logic [7:0] contrast_a;
    logic [7:0] contrast_b;
    logic [7:0] contrast_c;
    logic [7:0] precharge;
    logic [7:0] pre2_a;
    logic [7:0] pre2_b;
    logic [7:0] pre2_c;
    logic [4:0] deselect_level;
    logic [7:0] phase;
    logic [7:0] power_save;
  } panel_cfg_type;

  typedef struct packed {
    logic [7:0] col_start;
    logic [7:0] col_end;
    logic [7:0] row_start;
    logic [7:0] row_end;
  } window_type;

  typedef struct packed {
    logic valid;
    logic [7:0] data;
    logic [7:0] column;
  } pixel_type;

endpackage

// file: oled_panel_command_decoder.sv
`timescale 1ns/100ps
`default_nettype none
`include "oled_cmd_params.svh"

// Operation
// (RQ1) Reset held low forces display off and normal display mode.
// (RQ2) Reset selects 64-line multiplex, start line zero, offset zero.
// (RQ3) Reset selects non-remapped segment and common addressing.
// (RQ4) Reset loads the column address counter with zero.
// (RQ5) Reset sets master contrast to 0x0f.
// (RQ6) Reset sets colour A, B and C contrast to 0x80.
// (RQ7) Reset clears partial bits in the serial shift register.
// (RQ8) Opcodes 0xae and 0xaf turn display off and on.
// (RQ9) Opcodes 0xa4 to 0xa7 select display mode from low bits.
// (RQ10) Clock divide, offset and multiplex opcodes take one parameter.
// (RQ11) Master configuration takes parameter 1000111x; 0x8e selects external drive.
// (RQ12) Start line and remap opcodes each take one parameter.
// (RQ13) Master current uses low four bits; contrast A, B, C full bytes.
// (RQ14) Pre-charge level and second pre-charge speeds take one parameter.
// (RQ15) Common-deselect level keeps the five middle parameter bits.
// (RQ16) Phase period and power saving opcodes take one parameter.
// (RQ17) Column and row window opcodes take start and end bytes.
// (RQ18) Host powers up: display off, clear, drive supply, wait, display on.
// (RQ19) Host powers down: display off, drive supply off, wait 100 ms.
// (RQ20) Host should reset the device when noise corrupts the display.
// (RQ21) Data/command high means display data, low means command byte.
// (RQ22) Transfers are accepted only while chip select is low.
// (RQ23) Serial mode: data on bit 1, clock on bit 0.
// (RQ24) Decoder consumes each opcode's parameter bytes before a new opcode.
// (RQ25) Settings apply after the last parameter; unknown opcodes are ignored.
module oled_panel_command_decoder
  import oled_cmd_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic chip_reset_low,
  input wire logic serial_mode,
  input wire logic chip_select_low,
  input wire logic data_command_sel,
  input wire logic write_strobe_low,
  input wire logic [7:0] data_bus,
  output oled_cmd_pkg::panel_cfg_type panel_cfg,
  output oled_cmd_pkg::window_type window,
  output oled_cmd_pkg::pixel_type pixel,
  output logic external_drive
);
  import oled_cmd_pkg::*;

  // ------------------------------------------------------------
  // Pin synchronisers
  // ------------------------------------------------------------
  // Stage 0 feeds only stage 1; edges are seen where stages 1 and 2 agree.
  localparam int NPIN = 13;
  logic [NPIN-1:0] pins;
  logic [NPIN-1:0] s0_q;
  logic [NPIN-1:0] s1_q;
  logic [NPIN-1:0] s2_q;
  logic [NPIN-1:0] stable_q;

  assign pins = {chip_reset_low, serial_mode, chip_select_low, data_command_sel,
                 write_strobe_low, data_bus};

  always_ff @(posedge ref_clk) begin
    s0_q <= pins;
    s1_q <= s0_q;
    s2_q <= s1_q;
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      // Load what the pins show now: a fixed idle value would let a pin held
      // through reset look like a fresh clock or strobe edge right after it
      stable_q <= s2_q;
    end else begin
      stable_q <= (s1_q & s2_q) | (stable_q & (s1_q | s2_q));
    end
  end

  logic res_n;
  logic ser;
  logic cs_n;
  logic dc;
  logic wr_n;
  logic [7:0] dbus;
  assign res_n = stable_q[12];
  assign ser = stable_q[11];
  assign cs_n = stable_q[10];
  assign dc = stable_q[9];
  assign wr_n = stable_q[8];
  assign dbus = stable_q[7:0];

  logic init;
  assign init = rst | ~res_n;

  // ------------------------------------------------------------
  // Byte capture
  // ------------------------------------------------------------
  logic wr_prev_q;
  logic sclk_prev_q;
  logic [7:0] shift_q;
  logic [2:0] bit_cnt_q;
  logic byte_valid;
  logic [7:0] byte_data;
  logic ser_done;

  always_ff @(posedge ref_clk) begin
    wr_prev_q <= wr_n;
    sclk_prev_q <= dbus[0];
  end

  assign ser_done = ser && !cs_n && dbus[0] && !sclk_prev_q && bit_cnt_q == 3'd7;

  // Shift register cleared under reset and whenever chip select drops away
  always_ff @(posedge ref_clk) begin
    if (init || cs_n) begin // see (RQ7) (RQ22)
      shift_q <= 8'h00;
      bit_cnt_q <= 3'd0;
    end else if (ser && dbus[0] && !sclk_prev_q) begin // see (RQ23)
      shift_q <= {shift_q[6:0], dbus[1]};
      bit_cnt_q <= bit_cnt_q + 3'd1;
    end
  end

  // Parallel write taken on the rising edge of the write strobe
  always_comb begin
    byte_valid = 1'b0;
    byte_data = dbus;
    if (!init && !cs_n) begin // see (RQ22)
      if (ser) begin
        byte_valid = ser_done;
        byte_data = {shift_q[6:0], dbus[1]};
      end else begin
        byte_valid = wr_n && !wr_prev_q;
      end
    end
  end

  // ------------------------------------------------------------
  // Command decoder
  // ------------------------------------------------------------
  function automatic logic [1:0] param_count(input logic [7:0] op);
    case (op)
      `OP_CLOCK_DIV, `OP_OFFSET, `OP_MUX, `OP_MASTER_CFG, `OP_START_LINE,
      `OP_REMAP, `OP_MASTER_CUR, `OP_CONTRAST_A, `OP_CONTRAST_B,
      `OP_CONTRAST_C, `OP_PRECHARGE, `OP_PRE2_A, `OP_PRE2_B, `OP_PRE2_C,
      `OP_DESELECT, `OP_PHASE, `OP_POWER_SAVE: param_count = 2'd1;
      `OP_COL_WIN, `OP_ROW_WIN: param_count = 2'd2;
      default: param_count = 2'd0;
    endcase
  endfunction

  // Opcode families whose low bits carry the argument
  function automatic logic is_onoff(input logic [7:0] op);
    logic [7:0] base;
    base = `OP_DISP_OFF;
    is_onoff = op[7:1] == base[7:1];
  endfunction

  function automatic logic is_mode(input logic [7:0] op);
    logic [7:0] base;
    base = `OP_MODE_NORMAL;
    is_mode = op[7:2] == base[7:2];
  endfunction

  typedef enum logic [1:0] {
    DEC_OPCODE,
    DEC_PARAM1,
    DEC_PARAM2
  } dec_state_type;

  dec_state_type state_q;
  logic [7:0] op_q;
  logic [7:0] first_q;
  logic cmd_byte;
  assign cmd_byte = byte_valid && !dc; // see (RQ21)

  always_ff @(posedge ref_clk) begin
    if (init) begin
      state_q <= DEC_OPCODE;
      op_q <= 8'h00;
      first_q <= 8'h00;
    end else if (cmd_byte) begin
      case (state_q)
        DEC_OPCODE: begin
          op_q <= byte_data;
          if (param_count(byte_data) != 2'd0) begin // see (RQ24)
            state_q <= DEC_PARAM1;
          end
        end
        DEC_PARAM1: begin
          first_q <= byte_data;
          state_q <= (param_count(op_q) == 2'd2) ? DEC_PARAM2 : DEC_OPCODE; // see (RQ24)
        end
        DEC_PARAM2: state_q <= DEC_OPCODE;
        default: state_q <= DEC_OPCODE;
      endcase
    end
  end

  // The last expected parameter byte closes the command
  function automatic logic ends_command(input dec_state_type st, input logic [7:0] op);
    ends_command = (st == DEC_PARAM1 && param_count(op) == 2'd1) || st == DEC_PARAM2;
  endfunction

  logic last_param;
  assign last_param = cmd_byte && ends_command(state_q, op_q);

  // Parameter writes land only with the final parameter; on/off and mode land with the opcode byte; unknown opcodes fall through
  always_ff @(posedge ref_clk) begin
    if (init) begin
      panel_cfg.display_on <= 1'b0; // see (RQ1)
      panel_cfg.mode <= MODE_NORMAL; // see (RQ1)
      panel_cfg.mux_ratio <= `RST_MUX; // see (RQ2)
      panel_cfg.start_line <= `RST_ZERO; // see (RQ2)
      panel_cfg.offset <= `RST_ZERO; // see (RQ2)
      panel_cfg.remap <= `RST_ZERO; // see (RQ3)
      panel_cfg.clock_div <= `RST_CLOCK_DIV;
      panel_cfg.master_cfg <= `RST_MASTER_CFG;
      panel_cfg.master_current <= `RST_MASTER_CUR; // see (RQ5)
      panel_cfg.contrast_a <= `RST_CONTRAST; // see (RQ6)
      panel_cfg.contrast_b <= `RST_CONTRAST; // see (RQ6)
      panel_cfg.contrast_c <= `RST_CONTRAST; // see (RQ6)
      panel_cfg.precharge <= `RST_PRECHARGE;
      panel_cfg.pre2_a <= `RST_ZERO;
      panel_cfg.pre2_b <= `RST_ZERO;
      panel_cfg.pre2_c <= `RST_ZERO;
      panel_cfg.deselect_level <= `RST_DESELECT;
      panel_cfg.phase <= `RST_PHASE;
      panel_cfg.power_save <= `RST_POWER_SAVE;
      window.col_start <= `RST_ZERO;
      window.col_end <= `RST_COL_END;
      window.row_start <= `RST_ZERO;
      window.row_end <= `RST_ROW_END;
    end else if (cmd_byte && state_q == DEC_OPCODE) begin
      if (is_onoff(byte_data)) begin
        panel_cfg.display_on <= byte_data[0]; // see (RQ8)
      end
      if (is_mode(byte_data)) begin
        panel_cfg.mode <= disp_mode_type'(byte_data[1:0]); // see (RQ9)
      end
    end else if (last_param) begin
      case (op_q) // see (RQ25)
        `OP_CLOCK_DIV: panel_cfg.clock_div <= byte_data; // see (RQ10)
        `OP_OFFSET: panel_cfg.offset <= byte_data; // see (RQ10)
        `OP_MUX: panel_cfg.mux_ratio <= byte_data; // see (RQ10)
        `OP_MASTER_CFG: panel_cfg.master_cfg <= byte_data; // see (RQ11)
        `OP_START_LINE: panel_cfg.start_line <= byte_data; // see (RQ12)
        `OP_REMAP: panel_cfg.remap <= byte_data; // see (RQ12)
        `OP_MASTER_CUR: panel_cfg.master_current <= byte_data[3:0]; // see (RQ13)
        `OP_CONTRAST_A: panel_cfg.contrast_a <= byte_data; // see (RQ13)
        `OP_CONTRAST_B: panel_cfg.contrast_b <= byte_data; // see (RQ13)
        `OP_CONTRAST_C: panel_cfg.contrast_c <= byte_data; // see (RQ13)
        `OP_PRECHARGE: panel_cfg.precharge <= byte_data; // see (RQ14)
        `OP_PRE2_A: panel_cfg.pre2_a <= byte_data; // see (RQ14)
        `OP_PRE2_B: panel_cfg.pre2_b <= byte_data; // see (RQ14)
        `OP_PRE2_C: panel_cfg.pre2_c <= byte_data; // see (RQ14)
        `OP_DESELECT: panel_cfg.deselect_level <= byte_data[5:1]; // see (RQ15)
        `OP_PHASE: panel_cfg.phase <= byte_data; // see (RQ16)
        `OP_POWER_SAVE: panel_cfg.power_save <= byte_data; // see (RQ16)
        `OP_COL_WIN: begin
          window.col_start <= first_q; // see (RQ17)
          window.col_end <= byte_data;
        end
        `OP_ROW_WIN: begin
          window.row_start <= first_q; // see (RQ17)
          window.row_end <= byte_data;
        end
        default: ;
      endcase
    end
  end

  // Drive source follows the latched parameter; only a parameter of exactly 0x8e means external
  always_ff @(posedge ref_clk) begin
    if (init) begin
      external_drive <= 1'b0;
    end else if (last_param && op_q == `OP_MASTER_CFG) begin
      external_drive <= byte_data == `MASTER_CFG_EXT; // see (RQ11)
    end
  end

  // ------------------------------------------------------------
  // Display data path
  // ------------------------------------------------------------
  // Column counter wraps inside the window; no pixel RAM lives here.
  always_ff @(posedge ref_clk) begin
    if (init) begin
      pixel.valid <= 1'b0;
      pixel.data <= 8'h00;
      pixel.column <= `RST_ZERO; // see (RQ4)
    end else begin
      pixel.valid <= byte_valid && dc; // see (RQ21)
      if (last_param && op_q == `OP_COL_WIN) begin
        pixel.column <= first_q;
      end else if (pixel.valid) begin
        pixel.column <= (pixel.column >= window.col_end) ? window.col_start
                                                         : pixel.column + 8'h01;
      end
      if (byte_valid && dc) begin
        pixel.data <= byte_data;
      end
    end
  end

endmodule
`default_nettype wire

// file: oled_panel_command_decoder_chk.sv
`timescale 1ns/100ps
`default_nettype none
module oled_panel_command_decoder_chk
  import oled_cmd_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic chip_reset_low,
  input wire logic chip_select_low,
  input wire oled_cmd_pkg::panel_cfg_type panel_cfg,
  input wire oled_cmd_pkg::window_type window,
  input wire oled_cmd_pkg::pixel_type pixel,
  input wire logic external_drive
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);
  sequence rst_done; $fell(rst); endsequence
  // A quiet port for 8 cycles outlasts the pin synchronisers
  sequence port_quiet; (chip_select_low && chip_reset_low)[*8]; endsequence
  reset_display_a: assert property (rst_done |-> !panel_cfg.display_on &&
    panel_cfg.mode == MODE_NORMAL) else $error("display not off after reset");
  reset_mux_a: assert property (rst_done |-> panel_cfg.mux_ratio == 8'h3f &&
    panel_cfg.start_line == 8'h00 && panel_cfg.offset == 8'h00) else $error("bad mux reset");
  reset_map_a: assert property (rst_done |-> panel_cfg.remap == 8'h00 &&
    pixel.column == 8'h00) else $error("bad mapping reset");
  reset_current_a: assert property (rst_done |-> panel_cfg.master_current == 4'hf &&
    !external_drive) else $error("bad current reset");
  reset_contrast_a: assert property (rst_done |-> panel_cfg.contrast_a == 8'h80 &&
    panel_cfg.contrast_b == 8'h80 && panel_cfg.contrast_c == 8'h80) else $error("bad contrast");
  pin_reset_a: assert property (!chip_reset_low [*8] |-> !panel_cfg.display_on &&
    panel_cfg.contrast_b == 8'h80) else $error("pin reset not applied");
  port_idle_a: assert property (port_quiet |=> $stable(panel_cfg) && $stable(window) &&
    !pixel.valid) else $error("change while deselected");
  pixel_pulse_a: assert property (pixel.valid |=> !pixel.valid)
    else $error("pixel valid too long");
endmodule
bind oled_panel_command_decoder oled_panel_command_decoder_chk u_chk (.ref_clk(ref_clk),
  .rst(rst), .chip_reset_low(chip_reset_low), .chip_select_low(chip_select_low),
  .panel_cfg(panel_cfg), .window(window), .pixel(pixel), .external_drive(external_drive));
`default_nettype wire

// file: oled_host_model.sv
`timescale 1ns/100ps
`default_nettype none
module oled_host_model (
  input wire logic ref_clk,
  output logic chip_select_low,
  output logic data_command_sel,
  output logic write_strobe_low,
  output logic [7:0] data_bus
);
  initial begin
    {chip_select_low, data_command_sel, write_strobe_low, data_bus} = 11'h500;
  end
  task automatic gap(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask
  task automatic put(input logic cs_n, input logic dc, input logic [7:0] b);
    gap(1);
    chip_select_low = cs_n;
    data_command_sel = dc;
    data_bus = b;
    gap(5);
    write_strobe_low = 1'b0;
    gap(5);
    write_strobe_low = 1'b1;
    gap(5);
    chip_select_low = 1'b1;
    // Released lines show no stale byte
    data_bus = ~b;
    data_command_sel = ~dc;
    gap(5);
  endtask
  // Sends the first n bits MSB first; a short frame keeps chip select low
  task automatic sput(input logic dc, input logic [7:0] b, input int n);
    int i;
    gap(1);
    chip_select_low = 1'b0;
    data_command_sel = dc;
    for (i = 7; i > 7 - n; i--) begin
      data_bus = {6'h2a ^ {6{b[i]}}, b[i], 1'b0};
      gap(5);
      data_bus[0] = 1'b1;
      gap(5);
    end
    if (n == 8) begin
      chip_select_low = 1'b1;
      gap(5);
    end
  endtask
endmodule
`default_nettype wire

// file: tb_oled_panel_command_decoder.sv
`timescale 1ns/100ps
`default_nettype none
module tb_oled_panel_command_decoder;
  import oled_cmd_pkg::*;
  logic ref_clk, rst, chip_reset_low, serial_mode, chip_select_low, data_command_sel;
  logic write_strobe_low, external_drive;
  logic [7:0] data_bus, last_pix, last_col, p, s, e, f0;
  panel_cfg_type panel_cfg;
  window_type window;
  pixel_type pixel;
  int n_errors = 0, checked = 0, n_pix = 0, i;
  integer seed = 32'hab213338;
  logic [7:0] ops [16] = '{8'hb3, 8'ha2, 8'hc8, 8'ha1, 8'ha0, 8'h87, 8'h81, 8'h82, 8'h83,
    8'hbb, 8'h8a, 8'h8b, 8'h8c, 8'hbe, 8'hb1, 8'hb0};
  oled_panel_command_decoder u_oled_panel_command_decoder (.ref_clk, .rst, .chip_reset_low,
    .serial_mode, .chip_select_low, .data_command_sel, .write_strobe_low, .data_bus,
    .panel_cfg, .window, .pixel, .external_drive);
  oled_host_model u_oled_host_model (.ref_clk, .chip_select_low, .data_command_sel,
    .write_strobe_low, .data_bus);
  initial begin
    ref_clk = 1'b0;
    forever #2 ref_clk = ~ref_clk;
  end
  always @(posedge ref_clk) if (pixel.valid === 1'b1) begin
    n_pix <= n_pix + 1;
    last_pix <= pixel.data;
    last_col <= pixel.column;
  end
  task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
    checked++;
    if (seen !== exp) begin
      n_errors++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic print_verdict();
    if (n_errors == 0 && checked > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  function automatic logic [7:0] expect_of(input logic [7:0] op, input logic [7:0] v);
    case (op)
      8'h87: return {4'h0, v[3:0]};
      8'hbe: return {3'h0, v[5:1]};
      default: return v;
    endcase
  endfunction
  function automatic logic [7:0] field(input logic [7:0] op);
    case (op)
      8'hb3: return panel_cfg.clock_div;
      8'ha2: return panel_cfg.offset;
      8'hc8: return panel_cfg.mux_ratio;
      8'ha1: return panel_cfg.start_line;
      8'ha0: return panel_cfg.remap;
      8'h87: return {4'h0, panel_cfg.master_current};
      8'h81: return panel_cfg.contrast_a;
      8'h82: return panel_cfg.contrast_b;
      8'h83: return panel_cfg.contrast_c;
      8'hbb: return panel_cfg.precharge;
      8'h8a: return panel_cfg.pre2_a;
      8'h8b: return panel_cfg.pre2_b;
      8'h8c: return panel_cfg.pre2_c;
      8'hbe: return {3'h0, panel_cfg.deselect_level};
      8'hb1: return panel_cfg.phase;
      default: return panel_cfg.power_save;
    endcase
  endfunction
  task automatic reset_check();
    chk("display", {7'h0, panel_cfg.display_on}, 8'h00);
    chk("mode", {6'h0, panel_cfg.mode}, 8'h00);
    chk("mux", panel_cfg.mux_ratio, 8'h3f);
    chk("offset", panel_cfg.offset | panel_cfg.start_line, 8'h00);
    chk("remap", panel_cfg.remap, 8'h00);
    chk("column", pixel.column, 8'h00);
    chk("current", {4'h0, panel_cfg.master_current}, 8'h0f);
    chk("contrast a", panel_cfg.contrast_a, 8'h80);
    chk("contrast b", panel_cfg.contrast_b, 8'h80);
    chk("contrast c", panel_cfg.contrast_c, 8'h80);
  endtask
  initial begin
    {rst, chip_reset_low, serial_mode} = 3'b110;
    repeat (12) @(posedge ref_clk);
    #1 rst = 1'b0;
    u_oled_host_model.gap(6);
    reset_check();
    // Power-up order; the supply delay is scaled down to keep the run short
    u_oled_host_model.put(1'b0, 1'b0, 8'hae);
    for (i = 0; i < 4; i++) begin
      p = $random(seed);
      u_oled_host_model.put(1'b0, 1'b1, p);
    end
    chk("pixels", n_pix[7:0], 8'h04);
    chk("pix data", last_pix, p);
    chk("pix col", last_col, 8'h03);
    u_oled_host_model.gap(100);
    u_oled_host_model.put(1'b0, 1'b0, 8'haf);
    chk("display on", {7'h0, panel_cfg.display_on}, 8'h01);
    for (i = 0; i < 4; i++) begin
      u_oled_host_model.put(1'b0, 1'b0, 8'ha4 | i[7:0]);
      chk("mode", {6'h0, panel_cfg.mode}, i[7:0]);
    end
    foreach (ops[k]) begin
      p = $random(seed);
      p = (ops[k] == 8'hbe) ? p & 8'h3e : (ops[k] inside {8'hb0, 8'hbb}) ? p & 8'h1f : p;
      f0 = field(ops[k]);
      u_oled_host_model.put(1'b0, 1'b0, ops[k]);
      chk("early", field(ops[k]), f0);
      u_oled_host_model.put(1'b0, 1'b0, p);
      chk("param", field(ops[k]), expect_of(ops[k], p));
    end
    for (i = 0; i < 2; i++) begin
      s = $random(seed);
      e = $random(seed);
      u_oled_host_model.put(1'b0, 1'b0, i ? 8'h75 : 8'h15);
      u_oled_host_model.put(1'b0, 1'b0, s);
      u_oled_host_model.put(1'b0, 1'b0, e);
      chk("win start", i ? window.row_start : window.col_start, s);
      chk("win end", i ? window.row_end : window.col_end, e);
    end
    u_oled_host_model.put(1'b0, 1'b0, 8'had);
    u_oled_host_model.put(1'b0, 1'b0, 8'h8e);
    chk("ext drive", {7'h0, external_drive}, 8'h01);
    u_oled_host_model.put(1'b0, 1'b0, 8'had);
    u_oled_host_model.put(1'b0, 1'b0, 8'h8f);
    chk("ext drive", {7'h0, external_drive}, 8'h00);
    chk("master cfg", panel_cfg.master_cfg, 8'h8f);
    // An opcode-like parameter is consumed, an unknown opcode eats nothing
    u_oled_host_model.put(1'b0, 1'b0, 8'h81);
    u_oled_host_model.put(1'b0, 1'b0, 8'hae);
    chk("param opcode", panel_cfg.contrast_a, 8'hae);
    u_oled_host_model.put(1'b0, 1'b0, 8'h2e);
    u_oled_host_model.put(1'b0, 1'b0, 8'hae);
    chk("unknown", {7'h0, panel_cfg.display_on}, 8'h00);
    p = $random(seed);
    u_oled_host_model.put(1'b1, p[0], 8'haf);
    chk("deselected", {7'h0, panel_cfg.display_on}, 8'h00);
    chk("deselected pix", n_pix[7:0], 8'h04);
    serial_mode = 1'b1;
    p = $random(seed);
    u_oled_host_model.sput(1'b0, 8'h83, 8);
    u_oled_host_model.sput(1'b0, p, 8);
    chk("serial", panel_cfg.contrast_c, p);
    u_oled_host_model.sput(1'b0, 8'haf, 3);
    rst = 1'b1;
    u_oled_host_model.gap(3);
    rst = 1'b0;
    u_oled_host_model.gap(6);
    reset_check();
    u_oled_host_model.sput(1'b0, 8'haf, 8);
    chk("shift clear", {7'h0, panel_cfg.display_on}, 8'h01);
    p = $random(seed);
    p[0] = 1'b1;
    u_oled_host_model.sput(1'b0, 8'h82, 8);
    u_oled_host_model.sput(1'b0, p, 8);
    chk("contrast b", panel_cfg.contrast_b, p);
    chip_reset_low = 1'b0;
    u_oled_host_model.gap(10);
    chip_reset_low = 1'b1;
    u_oled_host_model.gap(8);
    reset_check();
    u_oled_host_model.sput(1'b0, 8'haf, 8);
    u_oled_host_model.sput(1'b0, 8'hae, 8);
    chk("power down", {7'h0, panel_cfg.display_on}, 8'h00);
    print_verdict();
  end
  initial begin
    #200000;
    n_errors++;
    print_verdict();
  end
endmodule
`default_nettype wire
